// file: rtl/tlvi_irq_unit.v
// Two level vectored interrupt unit: enable and priority registers,
// per-cycle arbitration, vector call sequencing and in-service tracking.
// Assumes pending flags and core strobes arrive from logic on ref_clk;
// pending flags live in the peripherals, which act on the clear pulses.
`include "tlvi_consts.vh"

module tlvi_irq_unit (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire [7:0] sfr_bit_addr,
  input wire sfr_bit_wr,
  input wire sfr_bit_wdata,
  input wire sfr_bit_rd,
  output reg sfr_bit_rdata,
  input wire ext_input_zero_pend,
  input wire timer0_ovf_pend,
  input wire ext_input_one_pend,
  input wire timer1_ovf_pend,
  input wire uart_rx_pend,
  input wire uart_tx_pend,
  input wire timer2_low_overflow,
  input wire timer2_high_overflow,
  input wire spi_transfer_done,
  input wire spi_write_collision,
  input wire spi_mode_fault,
  input wire spi_receive_overrun,
  input wire timer3_low_overflow,
  input wire timer3_high_overflow,
  input wire [17:7] xsrc_pend,
  input wire [17:7] xsrc_en,
  input wire [17:7] xsrc_prio,
  input wire instr_boundary,
  input wire return_from_isr,
  output reg irq_req_q,
  output reg [15:0] irq_vector_q,
  output reg irq_level_q,
  output reg long_vector_call_q,
  output reg [3:0] hw_flag_clr_q,
  output reg insvc_hi_q,
  output reg insvc_lo_q
);

  // Vector address of a source order number
  function [15:0] tlvi_vector;
    input [4:0] order;
    begin
      tlvi_vector = `TLVI_VEC_BASE + {8'h00, order, 3'b000};
    end
  endfunction

  // Bit address decode: upper five bits pick the byte, low three the bit
  function tlvi_bit_hit;
    input [7:0] bit_addr;
    input [7:0] byte_addr;
    begin
      tlvi_bit_hit = (bit_addr[7:3] == byte_addr[7:3]);
    end
  endfunction

  reg [7:0] enable_q;
  reg [7:0] enable_d;
  reg [6:0] prio_q;
  reg [6:0] prio_d;
  reg [2:0] call_cnt_q;
  reg [17:0] src_req;
  reg [17:0] src_prio;
  reg [7:0] prio_view;
  wire arb_found;
  wire [4:0] arb_idx;
  wire arb_level;
  wire call_busy;
  wire take;
  wire req_d;
  wire hi_busy;
  wire lo_busy;

  // Priority register as software sees it
  always @* begin
    prio_view = {`TLVI_PRIO_TOP, prio_q};
  end

  // Byte writes and single bit writes to enable and priority
  always @* begin
    enable_d = enable_q;
    prio_d = prio_q;
    if (sfr_wr && (sfr_addr == `TLVI_ADDR_ENABLE)) begin
      enable_d = sfr_wdata;
    end
    if (sfr_wr && (sfr_addr == `TLVI_ADDR_PRIO)) begin
      prio_d = sfr_wdata[6:0];
    end
    if (sfr_bit_wr && tlvi_bit_hit(sfr_bit_addr, `TLVI_ADDR_ENABLE)) begin
      enable_d[sfr_bit_addr[2:0]] = sfr_bit_wdata;
    end
    if (sfr_bit_wr && tlvi_bit_hit(sfr_bit_addr, `TLVI_ADDR_PRIO) &&
        (sfr_bit_addr[2:0] != 3'h7)) begin
      prio_d[sfr_bit_addr[2:0]] = sfr_bit_wdata;
    end
  end

  // Register storage
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= `TLVI_ENABLE_RST;
      prio_q <= `TLVI_PRIO_RST;
    end else begin
      enable_q <= enable_d;
      prio_q <= prio_d;
    end
  end

  // Byte and bit read answers, one clock after the strobe
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
      sfr_bit_rdata <= 1'b0;
    end else begin
      if (sfr_rd) begin
        if (sfr_addr == `TLVI_ADDR_ENABLE) begin
          sfr_rdata <= enable_q;
        end else if (sfr_addr == `TLVI_ADDR_PRIO) begin
          sfr_rdata <= prio_view;
        end else begin
          sfr_rdata <= 8'h00;
        end
      end
      if (sfr_bit_rd) begin
        if (tlvi_bit_hit(sfr_bit_addr, `TLVI_ADDR_ENABLE)) begin
          sfr_bit_rdata <= enable_q[sfr_bit_addr[2:0]];
        end else if (tlvi_bit_hit(sfr_bit_addr, `TLVI_ADDR_PRIO)) begin
          sfr_bit_rdata <= prio_view[sfr_bit_addr[2:0]];
        end else begin
          sfr_bit_rdata <= 1'b0;
        end
      end
    end
  end

  // Masked requests in fixed order; flags themselves ignore the enables
  always @* begin
    src_req = 18'h0_0000;
    src_req[`TLVI_SRC_EXT0] = ext_input_zero_pend &
                              enable_q[`TLVI_BIT_EXT0];
    src_req[`TLVI_SRC_TMR0] = timer0_ovf_pend & enable_q[`TLVI_BIT_TMR0];
    src_req[`TLVI_SRC_EXT1] = ext_input_one_pend &
                              enable_q[`TLVI_BIT_EXT1];
    src_req[`TLVI_SRC_TMR1] = timer1_ovf_pend & enable_q[`TLVI_BIT_TMR1];
    src_req[`TLVI_SRC_UART] = (uart_rx_pend | uart_tx_pend) &
                              enable_q[`TLVI_BIT_UART];
    src_req[`TLVI_SRC_TMR2] = (timer2_low_overflow |
                               timer2_high_overflow) &
                              enable_q[`TLVI_BIT_TMR2];
    src_req[`TLVI_SRC_SPI] = (spi_transfer_done | spi_write_collision |
                              spi_mode_fault | spi_receive_overrun) &
                             enable_q[`TLVI_BIT_SPI];
    src_req[17:7] = xsrc_pend & xsrc_en;
    src_req[`TLVI_SRC_TMR3] = (timer3_low_overflow |
                               timer3_high_overflow) &
                              xsrc_en[`TLVI_SRC_TMR3];
    src_req[`TLVI_SRC_NONE] = 1'b0;
    if (!enable_q[`TLVI_BIT_GATE]) begin
      src_req = 18'h0_0000;
    end
  end

  // Level of each source: basic register low, external inputs above
  always @* begin
    src_prio = {xsrc_prio, prio_q};
  end

  // Levels still busy once a return ending in this clock completes, so
  // a waiting request is raised at once and taken one instruction later
  assign hi_busy = insvc_hi_q & ~return_from_isr;
  assign lo_busy = insvc_lo_q & ~(return_from_isr & ~insvc_hi_q);

  // Arbitration: a level may enter only above what is in service;
  // a low routine gives way to high, a high routine to nothing
  tlvi_arbiter #(
    .N(`TLVI_NUM_SRC)
  ) tlvi_arbiter_inst (
    .req(src_req),
    .prio(src_prio),
    .allow_hi(~hi_busy),
    .allow_lo(~hi_busy & ~lo_busy),
    .found(arb_found),
    .idx(arb_idx),
    .level(arb_level)
  );

  // Call in progress from the take until the fourth call clock;
  // the request stays low meanwhile so the vector cannot change
  assign call_busy = (call_cnt_q != 3'h0);

  // Taken at an instruction end, never the one that ends a return
  assign take = irq_req_q & instr_boundary & ~return_from_isr &
                ~call_busy;

  // Request is rebuilt every clock; the register is the detect clock
  assign req_d = arb_found & ~take & ~call_busy;

  // Registered request, vector and level toward the core
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req_q <= 1'b0;
      irq_vector_q <= `TLVI_VEC_RESET;
      irq_level_q <= 1'b0;
    end else begin
      irq_req_q <= req_d;
      if (req_d) begin
        irq_vector_q <= tlvi_vector(arb_idx);
        irq_level_q <= arb_level;
      end
    end
  end

  // Vector call sequencer: four clocks of call after the take
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      call_cnt_q <= 3'h0;
      long_vector_call_q <= 1'b0;
    end else begin
      if (take) begin
        call_cnt_q <= `TLVI_CALL_CYCLES;
      end else if (call_busy) begin
        call_cnt_q <= call_cnt_q - 3'h1;
      end
      long_vector_call_q <= take | (call_cnt_q > 3'h1);
    end
  end

  // Hardware clears only the two external and two timer 0/1 flags;
  // the vector compared is the one latched with the request taken
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hw_flag_clr_q <= 4'h0;
    end else begin
      hw_flag_clr_q <= 4'h0;
      if (take && (irq_vector_q == tlvi_vector(`TLVI_SRC_EXT0))) begin
        hw_flag_clr_q[0] <= 1'b1;
      end
      if (take && (irq_vector_q == tlvi_vector(`TLVI_SRC_TMR0))) begin
        hw_flag_clr_q[1] <= 1'b1;
      end
      if (take && (irq_vector_q == tlvi_vector(`TLVI_SRC_EXT1))) begin
        hw_flag_clr_q[2] <= 1'b1;
      end
      if (take && (irq_vector_q == tlvi_vector(`TLVI_SRC_TMR1))) begin
        hw_flag_clr_q[3] <= 1'b1;
      end
    end
  end

  // In-service levels: set at take, highest one ends at each return
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      insvc_hi_q <= 1'b0;
      insvc_lo_q <= 1'b0;
    end else begin
      if (return_from_isr) begin
        if (insvc_hi_q) begin
          insvc_hi_q <= 1'b0;
        end else begin
          insvc_lo_q <= 1'b0;
        end
      end else if (take) begin
        if (irq_level_q) begin
          insvc_hi_q <= 1'b1;
        end else begin
          insvc_lo_q <= 1'b1;
        end
      end
    end
  end

endmodule

// file: rtl/tlvi_consts.vh
// Constants for the two level vectored interrupt unit.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TLVI_CONSTS_VH
`define TLVI_CONSTS_VH

// Special register byte addresses
`define TLVI_ADDR_ENABLE 8'hA8
`define TLVI_ADDR_PRIO 8'hB8

// Reset values
`define TLVI_ENABLE_RST 8'h00
`define TLVI_PRIO_RST 7'h00

// Enable register field positions
`define TLVI_BIT_GATE 7
`define TLVI_BIT_SPI 6
`define TLVI_BIT_TMR2 5
`define TLVI_BIT_UART 4
`define TLVI_BIT_TMR1 3
`define TLVI_BIT_EXT1 2
`define TLVI_BIT_TMR0 1
`define TLVI_BIT_EXT0 0

// Priority register bit 7 has no storage and reads as one
`define TLVI_PRIO_TOP 1'b1

// Fixed source order numbers
`define TLVI_SRC_EXT0 0
`define TLVI_SRC_TMR0 1
`define TLVI_SRC_EXT1 2
`define TLVI_SRC_TMR1 3
`define TLVI_SRC_UART 4
`define TLVI_SRC_TMR2 5
`define TLVI_SRC_SPI 6
`define TLVI_SRC_FIRST_X 7
`define TLVI_SRC_TMR3 13
`define TLVI_SRC_NONE 16
`define TLVI_SRC_PMATCH 17
`define TLVI_NUM_SRC 18

// Vector layout
`define TLVI_VEC_RESET 16'h0000
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_STEP 16'h0008

// Timing in system clocks
`define TLVI_DETECT_CYCLES 1
`define TLVI_CALL_CYCLES 3'h4

`endif

// file: rtl/tlvi_arbiter.v
// Priority arbiter of the two level vectored interrupt unit.
// Assumes purely combinational use; the caller registers the result.
`include "tlvi_consts.vh"

module tlvi_arbiter #(
  parameter N = `TLVI_NUM_SRC
) (
  input wire [N-1:0] req,
  input wire [N-1:0] prio,
  input wire allow_hi,
  input wire allow_lo,
  output reg found,
  output reg [4:0] idx,
  output reg level
);

  // Lowest order number among a set of requests
  function [4:0] tlvi_lowest;
    input [N-1:0] vec;
    integer k;
    begin
      tlvi_lowest = 5'h0_0;
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (vec[k]) begin
          tlvi_lowest = k[4:0];
        end
      end
    end
  endfunction

  wire [N-1:0] hi_req = req & prio;
  wire [N-1:0] lo_req = req & ~prio;

  // High level first, then fixed order inside the level
  always @* begin
    found = 1'b0;
    idx = 5'h0_0;
    level = 1'b0;
    if (allow_hi && (|hi_req)) begin
      found = 1'b1;
      idx = tlvi_lowest(hi_req);
      level = 1'b1;
    end else if (allow_lo && (|lo_req)) begin
      found = 1'b1;
      idx = tlvi_lowest(lo_req);
      level = 1'b0;
    end
  end

endmodule

// file: tb/tlvi_checker.sv
// Port checker for the interrupt unit.
// Assumes a bind to tlvi_irq_unit; one clock, active low reset.
module tlvi_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire instr_boundary,
  input wire return_from_isr,
  input wire irq_req_q,
  input wire [15:0] irq_vector_q,
  input wire irq_level_q,
  input wire long_vector_call_q,
  input wire [3:0] hw_flag_clr_q,
  input wire insvc_hi_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Call and take behaviour
  chk_call_four: assert property (
    $rose(long_vector_call_q) |-> long_vector_call_q [*4] ##1
    !long_vector_call_q) else $error("call length wrong");
  chk_take_call: assert property (
    irq_req_q && instr_boundary && !return_from_isr |=>
    long_vector_call_q && !irq_req_q) else $error("take missed");
  chk_ret_wait: assert property (
    return_from_isr |=> !long_vector_call_q)
    else $error("call right after return");
  chk_hi_block: assert property (
    insvc_hi_q |-> !irq_req_q) else $error("request under high");
  chk_vec_form: assert property (
    irq_req_q |-> irq_vector_q[2:0] == 3'h3 &&
    irq_vector_q <= 16'h008B) else $error("bad vector");
  chk_clr_pulse: assert property (
    |hw_flag_clr_q |-> $onehot(hw_flag_clr_q) &&
    $rose(long_vector_call_q)) else $error("stray clear");
  // Register reads
  chk_rd_empty: assert property (
    sfr_rd && sfr_addr != 8'hA8 && sfr_addr != 8'hB8 |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
  chk_prio_top: assert property (
    sfr_rd && sfr_addr == 8'hB8 |=> sfr_rdata[7])
    else $error("priority top bit low");
  cover property ($rose(long_vector_call_q));
  cover property ($fell(insvc_hi_q));
  cover property (irq_req_q && irq_level_q);
endmodule

// file: tb/tlvi_core_model.sv
// Behavioural core: instruction boundaries, returns, stall in calls.
// Assumes ilen zero halts the core; ret_cmd queues one return.
module tlvi_core_model (
  input wire ref_clk,
  input wire rst_b,
  input wire [3:0] ilen,
  input wire ret_cmd,
  input wire long_vector_call_q,
  output logic instr_boundary,
  output logic return_from_isr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic in_ret_q;
  // Last clock of an instruction, never inside the call
  assign instr_boundary = ilen != 4'h0 && !long_vector_call_q &&
    cnt_q == (in_ret_q ? 4'h4 : ilen - 4'h1);
  assign return_from_isr = instr_boundary && in_ret_q;
  // Clock count; a queued return becomes the next instruction
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      in_ret_q <= 1'b0;
    end else if (long_vector_call_q || ilen == 4'h0) begin
      cnt_q <= 4'h0;
    end else if (instr_boundary) begin
      cnt_q <= 4'h0;
      in_ret_q <= ret_cmd && !in_ret_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// file: tb/tlvi_irq_unit_tb_top.sv
// Self-checking bench for the interrupt unit and a core model.
// Assumes design, checker and core model are compiled first.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tlvi_irq_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] ip;
    logic [13:0] src;
    logic [10:0] xp;
    logic [10:0] xe;
    logic req;
    logic [15:0] vec;
    logic lvl;
  } tlvi_row_t;
  logic ref_clk, rst_b, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_wdata;
  logic sfr_bit_rd, ret_cmd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, rdat;
  logic [13:0] src;
  logic [10:0] xp, xe;
  logic [3:0] ilen;
  wire [7:0] sfr_rdata;
  wire [15:0] irq_vector_q;
  wire [3:0] hw_flag_clr_q;
  wire sfr_bit_rdata, instr_boundary, return_from_isr, irq_req_q;
  wire irq_level_q, long_vector_call_q, insvc_hi_q, insvc_lo_q;
  int num_errors, comparisons, n;
  tlvi_row_t rows [14] = '{
    '{8'h81, 0, 14'h0001, 0, 0, 1, 16'h0003, 0},
    '{8'h82, 0, 14'h0002, 0, 0, 1, 16'h000B, 0},
    '{8'h84, 0, 14'h0004, 0, 0, 1, 16'h0013, 0},
    '{8'h88, 0, 14'h0008, 0, 0, 1, 16'h001B, 0},
    '{8'h90, 0, 14'h0020, 0, 0, 1, 16'h0023, 0},
    '{8'hA0, 0, 14'h0040, 0, 0, 1, 16'h002B, 0},
    '{8'hA0, 8'h20, 14'h0080, 0, 0, 1, 16'h002B, 1},
    '{8'hC0, 0, 14'h0200, 0, 0, 1, 16'h0033, 0},
    '{8'h7F, 0, 14'h3FFF, 0, 0, 0, 16'h0000, 0},
    '{8'hFF, 0, 14'h3FFF, 0, 0, 1, 16'h0003, 0},
    '{8'hFF, 8'h40, 14'h3FFF, 0, 0, 1, 16'h0033, 1},
    '{8'h80, 0, 14'h1000, 0, 11'h040, 1, 16'h006B, 0},
    '{8'h80, 0, 14'h0000, 11'h500, 11'h7FF, 1, 16'h007B, 0},
    '{8'h80, 0, 14'h0800, 11'h400, 11'h7FF, 1, 16'h008B, 0}};
  tlvi_irq_unit tlvi_irq_unit_inst (
    .ref_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
    .sfr_bit_addr, .sfr_bit_wr, .sfr_bit_wdata, .sfr_bit_rd, .sfr_bit_rdata,
    .ext_input_zero_pend(src[0]), .timer0_ovf_pend(src[1]),
    .ext_input_one_pend(src[2]), .timer1_ovf_pend(src[3]),
    .uart_rx_pend(src[4]), .uart_tx_pend(src[5]),
    .timer2_low_overflow(src[6]), .timer2_high_overflow(src[7]),
    .spi_transfer_done(src[8]), .spi_write_collision(src[9]),
    .spi_mode_fault(src[10]), .spi_receive_overrun(src[11]),
    .timer3_low_overflow(src[12]), .timer3_high_overflow(src[13]),
    .xsrc_pend(xp), .xsrc_en(xe), .xsrc_prio(11'h000),
    .instr_boundary, .return_from_isr, .irq_req_q, .irq_vector_q,
    .irq_level_q, .long_vector_call_q, .hw_flag_clr_q, .insvc_hi_q,
    .insvc_lo_q);
  tlvi_core_model tlvi_core_model_inst (.ref_clk, .rst_b, .ilen,
    .ret_cmd, .long_vector_call_q, .instr_boundary, .return_from_isr);
  // Byte register access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 rdat = sfr_rdata;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Peripherals drop flags on the clear pulses
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++)
      if (hw_flag_clr_q[i]) src[i] <= 1'b0;
  end
  // Watchdog
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {rst_b, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_wdata, sfr_bit_rd} = 0;
    {sfr_addr, sfr_wdata, sfr_bit_addr, src, xp, xe, ilen, ret_cmd} = 0;
    repeat (5) @(posedge ref_clk);
    `CHK("vec_rst", 16'h0000, irq_vector_q)
    rst_b <= 1'b1;
    rd(8'hA8);
    `CHK("ie_rst", 8'h00, rdat)
    rd(8'hB8);
    `CHK("ip_rst", 8'h80, rdat)
    rd(8'hA9);
    `CHK("unmapped", 8'h00, rdat)
    // Bit write of the gate, bit read of the priority top bit
    @(posedge ref_clk);
    sfr_bit_addr <= 8'hAF;
    sfr_bit_wdata <= 1'b1;
    sfr_bit_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_bit_wr <= 1'b0;
    sfr_bit_addr <= 8'hBF;
    sfr_bit_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_bit_rd <= 1'b0;
    #1 `CHK("bit_top", 1'b1, sfr_bit_rdata)
    rd(8'hA8);
    `CHK("ie_bit", 8'h80, rdat)
    // Table rows with the core halted
    foreach (rows[i]) begin
      wr(8'hA8, rows[i].ie);
      wr(8'hB8, rows[i].ip);
      src <= rows[i].src;
      xp <= rows[i].xp;
      xe <= rows[i].xe;
      repeat (3) @(posedge ref_clk);
      #1 `CHK("req", rows[i].req, irq_req_q)
      if (rows[i].req) begin
        `CHK("vec", rows[i].vec, irq_vector_q)
        `CHK("lvl", rows[i].lvl, irq_level_q)
      end
      @(posedge ref_clk);
      src <= 14'h0000;
      xp <= 11'h000;
    end
    // Fastest answer with a high level source
    wr(8'hA8, 8'h81);
    wr(8'hB8, 8'h01);
    src <= 14'h0001;
    ilen <= 4'h1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("call_on", 1'b1, long_vector_call_q)
    `CHK("clr", 4'h1, hw_flag_clr_q)
    `CHK("insvc", 1'b1, insvc_hi_q)
    repeat (4) @(posedge ref_clk);
    #1 `CHK("call_off", 1'b0, long_vector_call_q)
    // Same level waits; return then a divide length instruction
    @(posedge ref_clk);
    ilen <= 4'h8;
    src[0] <= 1'b1;
    ret_cmd <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 `CHK("held", 1'b0, irq_req_q)
    n = 0;
    while (!return_from_isr && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    while (!long_vector_call_q && n < 40) begin
      @(posedge ref_clk);
      ret_cmd <= 1'b0;
      #1 n++;
    end
    // Return's last clock plus eight divide clocks
    `CHK("worst", 8 + 1, n)
    // Mid-run reset drops call, request and service state
    @(posedge ref_clk);
    rst_b <= 1'b0;
    ilen <= 4'h0;
    src <= 14'h0000;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("rst_call", 1'b0, long_vector_call_q)
    `CHK("rst_req", 1'b0, irq_req_q)
    `CHK("rst_hi", 1'b0, insvc_hi_q)
    `CHK("rst_lo", 1'b0, insvc_lo_q)
    @(posedge ref_clk);
    rst_b <= 1'b1;
    // Low level taken, then a high level preempts it
    wr(8'hA8, 8'h83);
    wr(8'hB8, 8'h02);
    src <= 14'h0001;
    ilen <= 4'h1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("lo_svc", 1'b1, insvc_lo_q)
    `CHK("lo_lvl", 1'b0, insvc_hi_q)
    @(posedge ref_clk);
    src[1] <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 `CHK("pre_hi", 1'b1, insvc_hi_q)
    `CHK("pre_lo", 1'b1, insvc_lo_q)
    `CHK("pre_vec", 16'h000B, irq_vector_q)
    `CHK("pre_clr", 4'h2, hw_flag_clr_q)
    tally_and_finish();
  end
endmodule
bind tlvi_irq_unit tlvi_checker tlvi_checker_inst (.ref_clk, .rst_b,
  .sfr_addr, .sfr_rd, .sfr_rdata, .instr_boundary, .return_from_isr,
  .irq_req_q, .irq_vector_q, .irq_level_q, .long_vector_call_q,
  .hw_flag_clr_q, .insvc_hi_q);
